// >>> hbr_pkg.sv
// shared constants for the serial port bit-rate generator
package hbr_pkg;
	// ************************************************
	// special-function register map
	// ************************************************
	localparam logic [7:0] PRESCALE_ADDR = 8'had;
	localparam logic [7:0] DIVIDER_ADDR = 8'hae;
	localparam logic [7:0] PRESCALE_RESET = 8'h18;
	localparam logic [7:0] DIVIDER_RESET = 8'h70;
	localparam int REG_WIDTH = 8;
	// ************************************************
	// timing
	// ************************************************
	localparam int CLK_PERIOD_NS = 4;
	localparam int CLK_FREQ_HZ = 1000000000 / CLK_PERIOD_NS;
endpackage : hbr_pkg

// >>> hbr_div_stage.sv
// one 8-bit up-counting divider stage with a terminal pulse
`timescale 1ns/1ps
module hbr_div_stage (
	input wire logic clk, // system clock
	input wire logic rst_n, // async reset, active low
	input wire logic run, // stage counts while high
	input wire logic step, // advance by one when high
	input wire logic [7:0] reload, // terminal count, cycles minus one
	output logic wrap // high in the step that ends a period
);
	logic [7:0] cnt_reg;
	logic [7:0] cnt_next;

	assign wrap = run && step && (cnt_reg >= reload);

	always_comb begin
		cnt_next = cnt_reg;
		if (!run) begin
			cnt_next = 8'h00;
		end else if (step) begin
			cnt_next = wrap ? 8'h00 : cnt_reg + 8'h01;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= 8'h00;
		end else begin
			cnt_reg <= cnt_next;
		end
	end
endmodule : hbr_div_stage

// >>> hbr_baud_gen.sv
// bit-rate generator of the high-speed serial host port
// Behaviour
// - bit rate is clock divided by (prescale plus one) times divider.
// - the divider setting divides directly, with no offset added.
// - the prescaler divides the clock by 1 to 256 ahead of the divider.
// - prescale register is 8-bit read/write at ad, reset value 18.
// - divider register is 8-bit read/write at ae, reset value 70.
// - with soft reset low the generator and its counting stop.
`timescale 1ns/1ps
module hbr_baud_gen (
	input wire logic clk, // system clock
	input wire logic rst_n, // async reset, active low
	input wire logic sfr_wr, // special-function register write strobe
	input wire logic sfr_rd, // special-function register read strobe
	input wire logic [7:0] sfr_addr, // register address
	input wire logic [7:0] sfr_wdata, // write data
	output logic [7:0] sfr_rdata, // read data, registered
	output logic sfr_hit, // address belongs to this block
	input wire logic soft_reset_n, // port soft reset, active low
	output logic baud_tick // one-cycle bit-rate tick
);
	// ************************************************
	// registers
	// ************************************************
	typedef enum logic [1:0] {
		HBR_IDLE = 2'b01,
		HBR_RUN = 2'b10
	} hbr_state_e;

	hbr_state_e state_reg;
	hbr_state_e state_next;
	logic [7:0] baud_prescale_reg;
	logic [7:0] baud_prescale_next;
	logic [7:0] baud_divider_reg;
	logic [7:0] baud_divider_next;
	logic [7:0] sfr_rdata_reg;
	logic [7:0] sfr_rdata_next;
	logic baud_tick_reg;
	logic baud_tick_next;
	logic pre_wrap;
	logic div_wrap;
	logic running;
	logic cfg_write;
	logic [7:0] div_reload;

	assign sfr_hit = (sfr_addr == hbr_pkg::PRESCALE_ADDR) ||
		(sfr_addr == hbr_pkg::DIVIDER_ADDR);
	assign sfr_rdata = sfr_rdata_reg;
	assign baud_tick = baud_tick_reg;

	always_comb begin
		baud_prescale_next = baud_prescale_reg;
		baud_divider_next = baud_divider_reg;
		sfr_rdata_next = sfr_rdata_reg;
		if (sfr_wr && sfr_addr == hbr_pkg::PRESCALE_ADDR) begin
			baud_prescale_next = sfr_wdata;
		end
		if (sfr_wr && sfr_addr == hbr_pkg::DIVIDER_ADDR) begin
			baud_divider_next = sfr_wdata;
		end
		if (sfr_rd) begin
			case (sfr_addr)
				hbr_pkg::PRESCALE_ADDR: sfr_rdata_next = baud_prescale_reg;
				hbr_pkg::DIVIDER_ADDR: sfr_rdata_next = baud_divider_reg;
				default: sfr_rdata_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			baud_prescale_reg <= hbr_pkg::PRESCALE_RESET;
			baud_divider_reg <= hbr_pkg::DIVIDER_RESET;
			sfr_rdata_reg <= 8'h00;
		end else begin
			baud_prescale_reg <= baud_prescale_next;
			baud_divider_reg <= baud_divider_next;
			sfr_rdata_reg <= sfr_rdata_next;
		end
	end

	// ************************************************
	// run control
	// ************************************************
	// a write to either setting restarts the period so no stale count leaks
	assign cfg_write = sfr_wr && sfr_hit;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			HBR_IDLE: if (soft_reset_n) state_next = HBR_RUN;
			HBR_RUN: if (!soft_reset_n || cfg_write) state_next = HBR_IDLE;
			default: state_next = HBR_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= HBR_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	assign running = (state_reg == HBR_RUN) && soft_reset_n;

	// ************************************************
	// divider chain
	// ************************************************
	// divider value 0 is taken as 256 counts, the natural 8-bit wrap
	assign div_reload = baud_divider_reg - 8'h01;

	hbr_div_stage u_pre (
		.clk(clk),
		.rst_n(rst_n),
		.run(running),
		.step(1'b1),
		.reload(baud_prescale_reg),
		.wrap(pre_wrap)
	);

	hbr_div_stage u_div (
		.clk(clk),
		.rst_n(rst_n),
		.run(running),
		.step(pre_wrap),
		.reload(div_reload),
		.wrap(div_wrap)
	);

	always_comb begin
		baud_tick_next = div_wrap;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			baud_tick_reg <= 1'b0;
		end else begin
			baud_tick_reg <= baud_tick_next;
		end
	end

	// ************************************************
	// checks
	// ************************************************
	// gap_cnt starts from zero on a restart so the first tick lands on period
	logic [16:0] gap_cnt;
	logic [16:0] gap_next;
	logic [16:0] pre_fac;
	logic [16:0] div_fac;
	logic [16:0] period;
	assign pre_fac = 17'(baud_prescale_reg) + 17'h00001;
	assign div_fac = (baud_divider_reg == 8'h00) ? 17'h00100 :
		17'(baud_divider_reg);
	assign period = pre_fac * div_fac;

	always_comb begin
		gap_next = gap_cnt + 17'h00001;
		if (!running) begin
			gap_next = 17'h00000;
		end else if (baud_tick_reg) begin
			gap_next = 17'h00001;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gap_cnt <= 17'h00000;
		end else begin
			gap_cnt <= gap_next;
		end
	end

	a_tick_period: assert property (@(posedge clk) disable iff (!rst_n)
		baud_tick_reg && $past(running) && $stable(baud_prescale_reg)
		&& $stable(baud_divider_reg) |-> gap_cnt == period)
		else $error("tick spacing differs from prescale times divider");
	a_tick_single: assert property (@(posedge clk) disable iff (!rst_n)
		baud_tick_reg && period != 17'h00001 |=> !baud_tick_reg)
		else $error("tick wider than one clock");
	a_soft_stop: assert property (@(posedge clk) disable iff (!rst_n)
		!soft_reset_n |=> !baud_tick_reg [*2])
		else $error("tick while soft reset held");
	a_pre_write: assert property (@(posedge clk) disable iff (!rst_n)
		sfr_wr && sfr_addr == hbr_pkg::PRESCALE_ADDR |=>
		baud_prescale_reg == $past(sfr_wdata))
		else $error("prescale write lost");
	a_div_write: assert property (@(posedge clk) disable iff (!rst_n)
		sfr_wr && sfr_addr == hbr_pkg::DIVIDER_ADDR |=>
		baud_divider_reg == $past(sfr_wdata))
		else $error("divider write lost");
	a_div_read: assert property (@(posedge clk) disable iff (!rst_n)
		sfr_rd && sfr_addr == hbr_pkg::DIVIDER_ADDR |=>
		sfr_rdata == $past(baud_divider_reg))
		else $error("divider readback wrong");
	a_pre_wrap: assert property (@(posedge clk) disable iff (!rst_n)
		running && baud_prescale_reg == 8'h00 && $past(running) |->
		pre_wrap)
		else $error("prescale of one does not pass every clock");
	a_tick_soon: assert property (@(posedge clk) disable iff (!rst_n)
		running && baud_prescale_reg == 8'h00 && baud_divider_reg == 8'h02
		&& !cfg_write [*3] |-> ##[0:3] baud_tick_reg)
		else $error("no tick within a short period");

	a_pre_read: assert property (@(posedge clk) disable iff (!rst_n)
		sfr_rd && sfr_addr == hbr_pkg::PRESCALE_ADDR |=>
		sfr_rdata == $past(baud_prescale_reg))
		else $error("prescale readback wrong");
	a_other_read: assert property (@(posedge clk) disable iff (!rst_n)
		sfr_rd && !sfr_hit |=> sfr_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_gap_bound: assert property (@(posedge clk) disable iff (!rst_n)
		running && $past(running) |-> gap_cnt <= period)
		else $error("tick missing after a full period");
	a_idle_quiet: assert property (@(posedge clk) disable iff (!rst_n)
		!running |=> !baud_tick_reg)
		else $error("tick while generator stopped");

	c_tick: cover property (@(posedge clk) baud_tick_reg);
	c_stop: cover property (@(posedge clk) baud_tick_reg ##1 !soft_reset_n);
	c_fast: cover property (@(posedge clk)
		baud_divider_reg == 8'h1d && baud_tick_reg);
	c_slow: cover property (@(posedge clk)
		baud_prescale_reg == 8'hff && baud_tick_reg);
	c_restart: cover property (@(posedge clk) cfg_write ##1 !running);
endmodule : hbr_baud_gen

// >>> hbr_tick_mon.sv
// serial control model that consumes and times the bit-rate tick
`timescale 1ns/1ps
module hbr_tick_mon (
	input wire logic clk, // system clock
	input wire logic rst_n, // async reset, active low
	input wire logic tick, // bit-rate tick from the generator
	output logic [16:0] gap, // clocks between the last two ticks
	output logic [15:0] n_ticks // ticks seen since reset
);
	logic [16:0] cnt;
	// host samples at whatever rate the last gap gives
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 17'h1;
			gap <= 17'h0;
			n_ticks <= 16'h0;
		end else if (tick) begin
			gap <= cnt;
			cnt <= 17'h1;
			n_ticks <= n_ticks + 16'h1;
		end else begin
			cnt <= cnt + 17'h1;
		end
	end
endmodule : hbr_tick_mon

// >>> tb.sv
// self-checking bench for the bit-rate generator
`timescale 1ns/1ps
module tb;
	logic clk = 0, rst_n = 0, wr = 0, rd = 0, srst_n = 1;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
	logic hit, tick;
	logic [16:0] gap;
	logic [15:0] nt;
	int fail_count = 0, n_checks = 0;
	always #2 clk = ~clk;
	hbr_baud_gen DUT (.clk(clk), .rst_n(rst_n), .sfr_wr(wr), .sfr_rd(rd),
		.sfr_addr(addr), .sfr_wdata(wdata), .sfr_rdata(rdata),
		.sfr_hit(hit), .soft_reset_n(srst_n), .baud_tick(tick));
	hbr_tick_mon mon (.clk(clk), .rst_n(rst_n), .tick(tick), .gap(gap),
		.n_ticks(nt));
	task chk(input logic [16:0] s, input logic [16:0] e);
		n_checks++;
		if (s !== e) begin
			fail_count++;
			$display("MISMATCH t=%0t seen %h want %h", $time, s, e);
		end
	endtask : chk
	task conclude;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : conclude
	task wr8(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr8
	task rd8(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata, e);
		chk(hit, a == 8'had || a == 8'hae);
	endtask : rd8
	// bounded wait for k more ticks
	task wait_ticks(input int k, input int bound);
		logic [15:0] s;
		s = nt;
		for (int i = 0; nt - s < k; i++) begin
			if (i > bound) begin
				chk(1'b0, 1'b1);
				break;
			end
			@(posedge clk);
		end
		#1;
	endtask : wait_ticks
	task test_regs;
		rd8(8'had, 8'h18);
		rd8(8'hae, 8'h70);
		rd8(8'hac, 8'h00);
		wr8(8'haf, 8'h55);
		rd8(8'hae, 8'h70);
		wr8(8'had, 8'ha5);
		wr8(8'hae, 8'h5a);
		rd8(8'had, 8'ha5);
		rd8(8'hae, 8'h5a);
		$display("test regs done");
	endtask : test_regs
	task test_period(input logic [7:0] p, input logic [7:0] d);
		int per;
		per = (p + 1) * (d == 8'h00 ? 256 : d);
		wr8(8'had, p);
		wr8(8'hae, d);
		wait_ticks(3, 4 * per + 20);
		chk(gap, per);
		chk(gap * 100 >= per * 98 && gap * 100 <= per * 102, 1'b1);
		$display("test period %0d done", per);
	endtask : test_period
	task test_soft;
		logic [15:0] s;
		@(posedge clk);
		srst_n <= 1'b0;
		repeat (3) @(posedge clk);
		s = nt;
		repeat (600) @(posedge clk);
		chk(nt, s);
		srst_n <= 1'b1;
		wait_ticks(3, 200);
		chk(gap, 17'h0001d);
		$display("test soft reset done");
	endtask : test_soft
	task test_reset;
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		rd8(8'had, 8'h18);
		rd8(8'hae, 8'h70);
		wait_ticks(3, 11300);
		chk(gap, 17'h00af0);
		$display("test mid-run reset done");
	endtask : test_reset
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		test_regs();
		test_period(8'h00, 8'h04);
		test_period(8'h02, 8'h03);
		test_period(8'hff, 8'h01);
		test_period(8'h00, 8'h01);
		test_period(8'h00, 8'h02);
		test_period(8'h00, 8'h00);
		test_period(8'h00, 8'heb);
		test_period(8'h18, 8'h71);
		test_period(8'h00, 8'h1d);
		test_soft();
		test_reset();
		conclude();
	end
endmodule : tb
